// *** src/dmf_top.sv ***
// drive monitor flags: detections, run timer, fan, hibernate, overload
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps

module dmf_top #(
  parameter int TICK_CYCLES = dmf_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // axi4-lite slave
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // drive measurements
  input  wire dmf_pkg::dmf_meas_t meas,
  // flag outputs
  output dmf_pkg::dmf_flags_t     flags
);

  // ==================================================
  // tick divider
  logic [31:0] divCnt_reg;
  logic        tick;

  assign tick = (divCnt_reg == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (rst || tick) begin
      divCnt_reg <= 32'h0;
    end else begin
      divCnt_reg <= divCnt_reg + 32'h1;
    end
  end

  // ==================================================
  // axi write path
  logic [31:0] cfg_reg [dmf_pkg::NUM_CFG];
  logic        awHeld_reg;
  logic        wHeld_reg;
  logic [7:0]  awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;
  logic        writeFire;
  logic        writeHit;

  assign s_axi_awready = !awHeld_reg;
  assign s_axi_wready  = !wHeld_reg;
  assign writeFire     = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  assign writeHit      = awAddr_reg[7:2] < 6'(dmf_pkg::NUM_CFG);

  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld_reg   <= 1'b0;
      wHeld_reg    <= 1'b0;
      awAddr_reg   <= 8'h0;
      wData_reg    <= 32'h0;
      wStrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dmf_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !awHeld_reg) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld_reg) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (writeFire) begin
        awHeld_reg   <= 1'b0;
        wHeld_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= writeHit ? dmf_pkg::RESP_OKAY : dmf_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int r = 0; r < dmf_pkg::NUM_CFG; r++) begin
      if (rst) begin
        cfg_reg[r] <= dmf_pkg::CFG_RST[r];
      end else if (writeFire && writeHit && awAddr_reg[7:2] == 6'(r)) begin
        for (int b = 0; b < 4; b++) begin
          if (wStrb_reg[b]) begin
            cfg_reg[r][8*b +: 8] <= wData_reg[8*b +: 8] & dmf_pkg::CFG_MASK[r][8*b +: 8];
          end
        end
      end
    end
  end

  // ==================================================
  // configuration fields
  logic        timerEn;
  logic        ovlEn;
  logic        fanMode;
  logic [1:0]  srcSel;
  logic [15:0] zcLevel;
  logic [15:0] ocLevel;
  logic [15:0] arrLevel [2];
  logic [15:0] arrWidth [2];
  logic [15:0] runTimeSet;
  logic [15:0] aiLow;
  logic [15:0] aiHigh;
  logic [7:0]  tempThr;
  logic [15:0] wakeFreq;
  logic [15:0] hibFreq;
  logic [15:0] ovlGain;
  logic [7:0]  ovlCoeff;

  assign timerEn     = cfg_reg[0][dmf_pkg::CTRL_TIMER_EN];
  assign ovlEn       = cfg_reg[0][dmf_pkg::CTRL_OVL_EN];
  assign fanMode     = cfg_reg[0][dmf_pkg::CTRL_FAN_MODE];
  assign srcSel      = cfg_reg[0][dmf_pkg::CTRL_SRC_LSB +: 2];
  assign zcLevel     = cfg_reg[1][15:0];
  assign ocLevel     = cfg_reg[2][15:0];
  assign arrLevel[0] = cfg_reg[3][15:0];
  assign arrWidth[0] = cfg_reg[3][31:16];
  assign arrLevel[1] = cfg_reg[4][15:0];
  assign arrWidth[1] = cfg_reg[4][31:16];
  assign runTimeSet  = cfg_reg[5][15:0];
  assign aiLow       = cfg_reg[6][15:0];
  assign aiHigh      = cfg_reg[6][31:16];
  assign tempThr     = cfg_reg[7][7:0];
  assign wakeFreq    = cfg_reg[8][15:0];
  assign hibFreq     = cfg_reg[9][15:0];
  assign ovlGain     = cfg_reg[10][15:0];
  assign ovlCoeff    = cfg_reg[10][23:16];

  // ==================================================
  // delayed detections: zero, over, sleep, wake
  dmf_pkg::dmf_hib_t hibState_reg;
  logic              hibEnable;
  logic [3:0]        cond;
  logic [3:0]        met;
  logic [19:0]       dly [4];

  assign hibEnable = (wakeFreq != 16'h0) || (hibFreq != 16'h0);
  assign cond[0] = meas.current <= zcLevel;
  assign cond[1] = (ocLevel != 16'h0) && meas.current >= ocLevel;
  assign cond[2] = hibEnable && meas.running && hibState_reg == dmf_pkg::HIB_AWAKE
                   && meas.freqRef <= hibFreq;
  assign cond[3] = hibState_reg == dmf_pkg::HIB_ASLEEP && meas.runCmd
                   && meas.freqRef >= wakeFreq;
  assign dly[0] = {4'h0, cfg_reg[1][31:16]};
  assign dly[1] = {4'h0, cfg_reg[2][31:16]};
  assign dly[2] = 20'(cfg_reg[9][31:16] * dmf_pkg::TICKS_PER_TENTH_S);
  assign dly[3] = 20'(cfg_reg[8][31:16] * dmf_pkg::TICKS_PER_TENTH_S);

  for (genvar i = 0; i < 4; i++) begin : g_delay
    logic [19:0] cnt_reg;
    always_ff @(posedge clk) begin
      if (rst || !cond[i]) begin
        cnt_reg <= 20'h0;
      end else if (tick && cnt_reg < dly[i]) begin
        cnt_reg <= cnt_reg + 20'h1;
      end
    end
    assign met[i] = cond[i] && cnt_reg >= dly[i];
  end

  // ==================================================
  // hibernate state
  always_ff @(posedge clk) begin
    if (rst) begin
      hibState_reg <= dmf_pkg::HIB_AWAKE;
    end else begin
      case (hibState_reg)
        dmf_pkg::HIB_AWAKE: begin
          if (met[2]) begin
            hibState_reg <= dmf_pkg::HIB_ASLEEP;
          end
        end
        dmf_pkg::HIB_ASLEEP: begin
          if (met[3] || !hibEnable || !meas.runCmd) begin
            hibState_reg <= dmf_pkg::HIB_AWAKE;
          end
        end
        default: hibState_reg <= dmf_pkg::HIB_AWAKE;
      endcase
    end
  end

  // ==================================================
  // current arrival windows
  logic [1:0] arrive;

  for (genvar k = 0; k < 2; k++) begin : g_arrive
    logic [16:0] diff;
    assign diff = meas.current >= arrLevel[k]
                  ? 17'(meas.current - arrLevel[k])
                  : 17'(arrLevel[k] - meas.current);
    assign arrive[k] = diff <= {1'b0, arrWidth[k]};
  end

  // ==================================================
  // run timer
  logic [15:0] srcAi;
  logic [31:0] scaled;
  logic [15:0] target;
  logic [15:0] elapsed_reg;
  logic [15:0] subTick_reg;
  logic        expired_reg;

  always_comb begin
    case (srcSel)
      2'h1:    srcAi = meas.firstAnalogInput;
      2'h2:    srcAi = meas.secondAnalogInput;
      2'h3:    srcAi = meas.thirdAnalogInput;
      default: srcAi = dmf_pkg::AI_FULL_SCALE;
    endcase
  end

  assign scaled = (32'(runTimeSet) * 32'(srcAi)) / 32'(dmf_pkg::AI_FULL_SCALE);
  assign target = (srcSel == 2'h0) ? runTimeSet
                  : (scaled > 32'(runTimeSet) ? runTimeSet : scaled[15:0]);

  always_ff @(posedge clk) begin
    if (rst || meas.startPulse) begin
      elapsed_reg <= 16'h0;
      subTick_reg <= 16'h0;
    end else if (timerEn && meas.running && tick && elapsed_reg < target) begin
      if (subTick_reg == 16'(dmf_pkg::TICKS_PER_TENTH_M - 1)) begin
        subTick_reg <= 16'h0;
        elapsed_reg <= elapsed_reg + 16'h1;
      end else begin
        subTick_reg <= subTick_reg + 16'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst || meas.startPulse || !timerEn) begin
      expired_reg <= 1'b0;
    end else if (meas.running && elapsed_reg >= target) begin
      expired_reg <= 1'b1;
    end
  end

  // ==================================================
  // overload inverse-time accumulator
  logic [31:0] ovlAcc_reg;
  logic [7:0]  ovlRate;
  logic [31:0] gainLvl;

  always_comb begin
    ovlRate = 8'h0;
    for (int j = 0; j < dmf_pkg::OVL_BANDS; j++) begin
      gainLvl = 32'(ovlGain) * 32'(dmf_pkg::OVL_BASE_PCT + 8'(j));
      if (32'(meas.current) >= gainLvl) begin
        ovlRate = dmf_pkg::OVL_RATE[j];
      end
    end
    gainLvl = 32'h0;
  end

  always_ff @(posedge clk) begin
    if (rst || !ovlEn) begin
      ovlAcc_reg <= 32'h0;
    end else if (tick) begin
      if (ovlRate != 8'h0) begin
        if (ovlAcc_reg < 32'(dmf_pkg::OVL_LIMIT)) begin
          ovlAcc_reg <= ovlAcc_reg + 32'(ovlRate);
        end
      end else if (ovlAcc_reg != 32'h0) begin
        ovlAcc_reg <= ovlAcc_reg - 32'h1;
      end
    end
  end

  // ==================================================
  // registered flags
  always_ff @(posedge clk) begin
    if (rst) begin
      flags <= '0;
    end else begin
      flags.zeroCurrent     <= met[0];
      flags.overcurrent     <= met[1];
      flags.arrivalA        <= arrive[0];
      flags.arrivalB        <= arrive[1];
      flags.timerExpired    <= expired_reg;
      flags.runStop         <= expired_reg;
      flags.analogRange     <= meas.firstAnalogInput > aiHigh
                               || meas.firstAnalogInput < aiLow;
      flags.overheat        <= meas.heatsinkTemp >= tempThr;
      flags.fanOn           <= fanMode || meas.running
                               || meas.heatsinkTemp > dmf_pkg::FAN_TEMP_C;
      flags.hibernate       <= hibState_reg == dmf_pkg::HIB_ASLEEP;
      flags.overloadFault   <= ovlEn && ovlAcc_reg >= 32'(dmf_pkg::OVL_LIMIT);
      flags.overloadPrewarn <= ovlEn && 40'(ovlAcc_reg) * 40'd100
                               >= 40'(dmf_pkg::OVL_LIMIT) * 40'(ovlCoeff);
    end
  end

  // ==================================================
  // axi read path
  logic [31:0] readMux;
  logic        readHit;
  logic [15:0] remaining;

  assign remaining = (target > elapsed_reg) ? target - elapsed_reg : 16'h0;

  always_comb begin
    readHit = 1'b1;
    readMux = 32'h0;
    if (s_axi_araddr[7:2] < 6'(dmf_pkg::NUM_CFG)) begin
      readMux = cfg_reg[s_axi_araddr[5:2]];
    end else if (s_axi_araddr == dmf_pkg::REG_STATUS) begin
      readMux = {20'h0, flags};
    end else if (s_axi_araddr == dmf_pkg::REG_REMAIN) begin
      readMux = {16'h0, remaining};
    end else begin
      readHit = 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= dmf_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= readMux;
      s_axi_rresp  <= readHit ? dmf_pkg::RESP_OKAY : dmf_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// *** src/dmf_pkg.sv ***
// constants, carriers and register map of the drive monitor block
package dmf_pkg;

  // ==================================================
  // clock and time base
  localparam int CLK_FREQ_HZ       = 250_000_000;
  localparam int TICK_PERIOD_MS    = 10;
  localparam int TICK_CYCLES       = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;
  localparam int TENTH_S_MS        = 100;
  localparam int TENTH_MIN_MS      = 6000;
  localparam int TICKS_PER_TENTH_S = TENTH_S_MS / TICK_PERIOD_MS;
  localparam int TICKS_PER_TENTH_M = TENTH_MIN_MS / TICK_PERIOD_MS;

  // ==================================================
  // fixed levels
  localparam logic [7:0]  FAN_TEMP_C    = 8'h28;
  localparam logic [15:0] AI_FULL_SCALE = 16'h03e8;
  localparam int          OVL_LONG_MIN  = 60;
  localparam int          OVL_LIMIT     = OVL_LONG_MIN * 60 * 1000 / TICK_PERIOD_MS;
  localparam int          OVL_BANDS     = 8;
  localparam logic [7:0]  OVL_BASE_PCT  = 8'h0f;
  localparam logic [7:0]  OVL_RATE [OVL_BANDS] =
    '{8'h01, 8'h02, 8'h04, 8'h08, 8'h0f, 8'h18, 8'h28, 8'h3c};

  // ==================================================
  // register map
  localparam int         NUM_CFG       = 11;
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_ZERO_CUR  = 8'h04;
  localparam logic [7:0] REG_OVER_CUR  = 8'h08;
  localparam logic [7:0] REG_ARRIVAL_A = 8'h0c;
  localparam logic [7:0] REG_ARRIVAL_B = 8'h10;
  localparam logic [7:0] REG_RUN_TIME  = 8'h14;
  localparam logic [7:0] REG_ANALOG    = 8'h18;
  localparam logic [7:0] REG_TEMP      = 8'h1c;
  localparam logic [7:0] REG_WAKE      = 8'h20;
  localparam logic [7:0] REG_HIBERNATE = 8'h24;
  localparam logic [7:0] REG_OVERLOAD  = 8'h28;
  localparam logic [7:0] REG_STATUS    = 8'h2c;
  localparam logic [7:0] REG_REMAIN    = 8'h30;

  // control field positions
  localparam int CTRL_TIMER_EN = 0;
  localparam int CTRL_OVL_EN   = 1;
  localparam int CTRL_FAN_MODE = 2;
  localparam int CTRL_SRC_LSB  = 4;

  localparam logic [31:0] CFG_RST [NUM_CFG] = '{
    32'h0000_0002, 32'h000a_0032, 32'h0000_07d0, 32'h0000_03e8,
    32'h0000_03e8, 32'h0000_0000, 32'h02a8_0136, 32'h0000_004b,
    32'h0000_0000, 32'h0000_0000, 32'h0050_0064};
  localparam logic [31:0] CFG_MASK [NUM_CFG] = '{
    32'h0000_0037, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
    32'hffff_ffff, 32'h0000_ffff, 32'hffff_ffff, 32'h0000_00ff,
    32'hffff_ffff, 32'hffff_ffff, 32'h00ff_ffff};

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==================================================
  // carriers
  typedef struct packed {
    logic [15:0] current;
    logic [15:0] freqRef;
    logic [15:0] firstAnalogInput;
    logic [15:0] secondAnalogInput;
    logic [15:0] thirdAnalogInput;
    logic [7:0]  heatsinkTemp;
    logic        running;
    logic        runCmd;
    logic        startPulse;
  } dmf_meas_t;

  typedef struct packed {
    logic overloadPrewarn;
    logic overloadFault;
    logic hibernate;
    logic fanOn;
    logic overheat;
    logic analogRange;
    logic runStop;
    logic timerExpired;
    logic arrivalB;
    logic arrivalA;
    logic overcurrent;
    logic zeroCurrent;
  } dmf_flags_t;

  typedef enum logic {HIB_AWAKE, HIB_ASLEEP} dmf_hib_t;

endpackage

// *** bench/dmf_drive_model.sv ***
// drive measurement path model feeding the monitor
`timescale 1ns/1ps
module dmf_drive_model (
  // clock
  input  wire logic          clk,
  // requested drive state
  input  wire logic [15:0]   cur,
  input  wire logic [15:0]   freq,
  input  wire logic [15:0]   ai1,
  input  wire logic [7:0]    temp,
  input  wire logic          run,
  input  wire logic          cmd,
  // measurement bundle
  output dmf_pkg::dmf_meas_t meas
);
  // ==========
  // sampled measurements
  always_ff @(posedge clk) begin
    meas.current <= cur;
    meas.freqRef <= freq;
    meas.firstAnalogInput <= ai1;
    meas.secondAnalogInput <= ~ai1;
    meas.thirdAnalogInput <= 16'h01f4;
    meas.heatsinkTemp <= temp;
    meas.running <= run;
    meas.runCmd <= cmd;
    meas.startPulse <= run && !meas.running;
  end
endmodule

// *** bench/dmf_top_asserts.sv ***
// port assertions for the drive monitor
`timescale 1ns/1ps
module dmf_top_asserts (
  // clock and reset
  input wire logic                clk,
  input wire logic                rst,
  // register bus
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [31:0]         s_axi_rdata,
  // drive side
  input wire dmf_pkg::dmf_meas_t  meas,
  input wire dmf_pkg::dmf_flags_t flags
);
  // ==========
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wrDone; s_axi_bvalid && s_axi_bready; endsequence
  sequence s_arTake; s_axi_arvalid && s_axi_arready; endsequence
  property p_wrDone; s_wrDone |=> !s_axi_bvalid; endproperty
  property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_rAns; s_arTake |=> s_axi_rvalid; endproperty
  property p_arRdy; s_axi_arready == !s_axi_rvalid; endproperty
  property p_stop; flags.runStop == flags.timerExpired; endproperty
  property p_fanRun; meas.running |=> flags.fanOn; endproperty
  property p_fanHot; meas.heatsinkTemp > dmf_pkg::FAN_TEMP_C |=> flags.fanOn; endproperty
  property p_start; meas.startPulse |=> ##1 !flags.timerExpired; endproperty
  property p_hibRun; $rose(flags.hibernate) |-> $past(meas.running); endproperty
  a_wrDone: assert property (p_wrDone) else $error("write answer stayed");
  a_bHold: assert property (p_bHold) else $error("write answer dropped");
  a_rHold: assert property (p_rHold) else $error("read answer dropped");
  a_rAns: assert property (p_rAns) else $error("read answer late");
  a_arRdy: assert property (p_arRdy) else $error("read ready wrong");
  a_stop: assert property (p_stop) else $error("stop and expiry differ");
  a_fanRun: assert property (p_fanRun) else $error("fan off while running");
  a_fanHot: assert property (p_fanHot) else $error("fan off while hot");
  a_start: assert property (p_start) else $error("expiry kept at start");
  a_hibRun: assert property (p_hibRun) else $error("sleep while stopped");
endmodule

bind dmf_top dmf_top_asserts chk (.clk(clk), .rst(rst), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .meas(meas), .flags(flags));

// *** bench/dmf_top_tb.sv ***
// self-checking bench for the drive monitor
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin nMismatch++; $display("wrong value at %0t: %0h not %0h", $time, a, b); end end
module dmf_top_tb;
  // ==========
  // signals
  logic                clk, rst, awvalid, wvalid, bready, arvalid, rready, run, cmd;
  logic                awready, wready, bvalid, arready, rvalid;
  logic [1:0]          bresp, rresp, rs;
  logic [7:0]          awaddr, araddr, temp;
  logic [15:0]         cur, freq, ai1;
  logic [31:0]         wdata, rdata, rd;
  dmf_pkg::dmf_meas_t  meas;
  dmf_pkg::dmf_flags_t flags;
  int                  nMismatch, comparisons;
  localparam int ZC = 0, OC = 1, AA = 2, AB = 3, TE = 4, RS = 5, AR = 6, OH = 7, FN = 8, HB = 9, OF = 10, OP = 11;

  dmf_top #(.TICK_CYCLES(4)) uut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .meas(meas), .flags(flags));
  dmf_drive_model drv (.clk(clk), .cur(cur), .freq(freq), .ai1(ai1), .temp(temp), .run(run), .cmd(cmd),
    .meas(meas));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========
  // bus and wait tasks
  task automatic results;
    $display("mismatches %0d comparisons %0d", nMismatch, comparisons);
    if (nMismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic hang(input int n);
    if (n >= 200) begin
      nMismatch++;
      $display("wrong value at %0t: no answer", $time);
      results();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 1'b0;
    hang(n);
  endtask
  task automatic rdReg(input logic [7:0] a);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rs = rresp;
    rd = rdata;
    rready <= 1'b0;
    hang(n);
  endtask
  task automatic waitf(input int i, input logic v, input int b);
    int n;
    for (n = 0; n < b && flags[i] !== v; n++) @(posedge clk);
    if (n == b) hang(200);
    `CHK(flags[i], v)
  endtask

  // ==========
  // scenarios
  task automatic tRegs;
    rdReg(dmf_pkg::REG_CTRL);
    `CHK(rd, 32'h0000_0002)
    wrReg(dmf_pkg::REG_TEMP, 32'h1234_564b);
    rdReg(dmf_pkg::REG_TEMP);
    `CHK(rd, 32'h0000_004b)
    wrReg(8'h40, 32'h0000_0001);
    `CHK(rs, dmf_pkg::RESP_SLVERR)
    rdReg(8'h40);
    `CHK({rs, rd}, {dmf_pkg::RESP_SLVERR, 32'h0000_0000})
    $display("registers done");
  endtask
  task automatic tLevels;
    cur <= 16'h0064;
    waitf(ZC, 1'b0, 6);
    wrReg(dmf_pkg::REG_ZERO_CUR, 32'h0004_0032);
    cur <= 16'h0032;
    cyc(8);
    `CHK(flags[ZC], 1'b0)
    waitf(ZC, 1'b1, 24);
    cur <= 16'h0033;
    waitf(ZC, 1'b0, 5);
    cur <= 16'h07d0;
    waitf(OC, 1'b1, 5);
    cur <= 16'h07cf;
    waitf(OC, 1'b0, 5);
    wrReg(dmf_pkg::REG_OVER_CUR, 32'h0000_0000);
    cur <= 16'h07d0;
    cyc(8);
    `CHK(flags[OC], 1'b0)
    wrReg(dmf_pkg::REG_ARRIVAL_A, 32'h0032_03e8);
    wrReg(dmf_pkg::REG_ARRIVAL_B, 32'h0000_01f4);
    cur <= 16'h041a;
    waitf(AA, 1'b1, 5);
    `CHK(flags[AB], 1'b0)
    cur <= 16'h041b;
    waitf(AA, 1'b0, 5);
    cur <= 16'h01f4;
    waitf(AB, 1'b1, 5);
    `CHK(flags[AA], 1'b0)
    $display("current levels done");
  endtask
  task automatic tAnalog;
    logic [15:0] v [4] = '{16'h0135, 16'h0136, 16'h02a8, 16'h02a9};
    for (int k = 0; k < 4; k++) begin
      ai1 <= v[k];
      cyc(4);
      `CHK(flags[AR], k == 0 || k == 3)
    end
    $display("analog window done");
  endtask
  task automatic tFan;
    temp <= 8'h29;
    waitf(FN, 1'b1, 5);
    temp <= 8'h28;
    waitf(FN, 1'b0, 5);
    temp <= 8'h4b;
    waitf(OH, 1'b1, 5);
    temp <= 8'h4a;
    waitf(OH, 1'b0, 5);
    temp <= 8'h14;
    run <= 1'b1;
    waitf(FN, 1'b1, 5);
    run <= 1'b0;
    waitf(FN, 1'b0, 5);
    wrReg(dmf_pkg::REG_CTRL, 32'h0000_0006);
    waitf(FN, 1'b1, 5);
    wrReg(dmf_pkg::REG_CTRL, 32'h0000_0002);
    $display("fan and heat done");
  endtask
  task automatic tTimer;
    wrReg(dmf_pkg::REG_RUN_TIME, 32'h0000_0001);
    wrReg(dmf_pkg::REG_CTRL, 32'h0000_0003);
    run <= 1'b1;
    cyc(4);
    rdReg(dmf_pkg::REG_REMAIN);
    `CHK(rd, 32'h0000_0001)
    cyc(2000);
    `CHK(flags[TE], 1'b0)
    waitf(TE, 1'b1, 800);
    `CHK(flags[RS], 1'b1)
    rdReg(dmf_pkg::REG_REMAIN);
    `CHK(rd, 32'h0000_0000)
    run <= 1'b0;
    cyc(2);
    run <= 1'b1;
    waitf(TE, 1'b0, 5);
    run <= 1'b0;
    wrReg(dmf_pkg::REG_RUN_TIME, 32'h0000_0014);
    wrReg(dmf_pkg::REG_CTRL, 32'h0000_0032);
    rdReg(dmf_pkg::REG_REMAIN);
    `CHK(rd, 32'h0000_000a)
    wrReg(dmf_pkg::REG_CTRL, 32'h0000_0002);
    $display("run timer done");
  endtask
  task automatic tHib;
    cmd <= 1'b1;
    run <= 1'b1;
    wrReg(dmf_pkg::REG_WAKE, 32'h0000_00c8);
    wrReg(dmf_pkg::REG_HIBERNATE, 32'h0000_0064);
    freq <= 16'h0032;
    waitf(HB, 1'b1, 8);
    freq <= 16'h012c;
    waitf(HB, 1'b0, 8);
    wrReg(dmf_pkg::REG_WAKE, 32'h0000_0000);
    wrReg(dmf_pkg::REG_HIBERNATE, 32'h0000_0000);
    freq <= 16'h0000;
    cyc(10);
    `CHK(flags[HB], 1'b0)
    run <= 1'b0;
    $display("hibernate done");
  endtask
  task automatic tOvl;
    cur <= 16'h0898;
    waitf(OP, 1'b1, 25000);
    `CHK(flags[OF], 1'b0)
    waitf(OF, 1'b1, 6000);
    wrReg(dmf_pkg::REG_CTRL, 32'h0000_0000);
    waitf(OP, 1'b0, 8);
    `CHK(flags[OF], 1'b0)
    $display("overload done");
  endtask

  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready, run, cmd} = 8'h80;
    {awaddr, araddr, wdata} = 48'h0;
    {cur, freq, ai1, temp} = 56'h0000_012c_01f4_14;
    nMismatch = 0;
    comparisons = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    tRegs();
    tLevels();
    tAnalog();
    tFan();
    tTimer();
    tHib();
    tOvl();
    results();
  end
endmodule
